// >>> verilog/timer16_access.sv
// What this block does
// - Compare match sets flag A, B or C
// - Qualifying capture edge copies counter to capture
// - Optional noise filter ahead of edge detect
// - Mode selects fixed or register-defined top
// - Compare A as top disables its PWM
// - Compare A top value is double buffered
// - Bottom signalled when counter equals zero
// - Max signalled when counter is all ones
// - One shared high-byte holding register
// - Low-byte access performs the 16-bit transfer
// - Low write loads holding byte plus data
// - Counter or capture low read copies high byte to holding
// - Compare high-byte reads bypass holding register
// - Counter high location reaches holding register
`timescale 1ns/10ps
module timer16_access
    import timer16_pkg::*;
(
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire cpu_req_type      cpu_req_in,
    output logic [7:0]            cpu_rdata_out,
    input  wire logic             count_tick_in,
    input  wire logic             count_up_in,
    input  wire logic             count_clear_in,
    input  wire top_sel_type      top_sel_in,
    input  wire logic             pwm_mode_in,
    input  wire logic             capture_pin_in,
    input  wire logic             comparator_in,
    input  wire logic             use_comparator_in,
    input  wire logic             filter_enable_in,
    input  wire logic             capture_rising_in,
    input  wire logic [2:0]       flag_clear_in,
    input  wire logic             capture_flag_clear_in,
    output logic [2:0]            compare_match_flags_out,
    output logic                  capture_flag_out,
    output logic                  pwm_a_allowed_out,
    output boundary_type          boundary_out,
    output logic [15:0]           timer_count_value_out,
    output logic [15:0]           top_value_out
);
    logic [7:0]  holding_ff;
    logic [15:0] timer_count_value_ff;
    logic [15:0] compare_value_a_ff;
    logic [15:0] compare_a_buf_ff;
    logic [15:0] compare_b_ff;
    logic [15:0] compare_c_ff;
    logic [15:0] capture_value_ff;
    logic [2:0]  compare_match_flags_ff;
    logic        capture_flag_ff;
    logic [7:0]  rdata_ff;
    logic [1:0]  pin_sync_ff;
    logic [1:0]  cmp_sync_ff;
    logic        edge_prev_ff;
    logic        filtered;
    logic        trig_src;
    logic        capture_event;
    logic        cap_defines_top;
    logic        cmpa_defines_top;
    logic [15:0] top_value;
    logic        at_top;
    logic        cpu_wr_cnt;
    logic        wr_lo;
    logic        rd_lo;
    logic [3:0]  addr;
    logic [15:0] nxt_count;
    logic [2:0]  match;

    assign addr  = cpu_req_in.addr;
    assign wr_lo = cpu_req_in.wr && !addr[0];
    assign rd_lo = cpu_req_in.rd && !addr[0];
    assign cpu_wr_cnt = wr_lo && (addr == LOC_CNT_LO);

    assign cap_defines_top  = (top_sel_in == TOP_SEL_CAP);
    assign cmpa_defines_top = (top_sel_in == TOP_SEL_CMPA);

    // Top selection from the operating mode
    always_comb begin
        case (top_sel_in)
            TOP_SEL_8BIT:  top_value = TOP_8BIT;
            TOP_SEL_9BIT:  top_value = TOP_9BIT;
            TOP_SEL_10BIT: top_value = TOP_10BIT;
            TOP_SEL_CMPA:  top_value = compare_value_a_ff;
            TOP_SEL_CAP:   top_value = capture_value_ff;
            default:       top_value = MAX_VALUE;
        endcase
    end

    assign at_top = (timer_count_value_ff == top_value);

    // Shared holding register: high-byte writes and low-byte reads
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            holding_ff <= RESET_VALUE8;
        end else if (cpu_req_in.wr && addr[0]) begin
            holding_ff <= cpu_req_in.wdata;
        end else if (rd_lo) begin
            if (addr == LOC_CNT_LO) begin
                holding_ff <= timer_count_value_ff[15:8];
            end else if (addr == LOC_CAP_LO) begin
                holding_ff <= capture_value_ff[15:8];
            end
            // Compare low reads leave it alone, so a pending high byte survives them
        end
    end

    // Counter: a CPU write overrides counting and clearing
    always_comb begin
        nxt_count = timer_count_value_ff;
        if (cpu_wr_cnt) begin
            nxt_count = {holding_ff, cpu_req_in.wdata};
        end else if (count_tick_in) begin
            if (count_clear_in || (count_up_in && at_top)) begin
                nxt_count = BOTTOM_VALUE;
            end else if (count_up_in) begin
                nxt_count = timer_count_value_ff + 16'h0001;
            end else begin
                nxt_count = timer_count_value_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            timer_count_value_ff <= RESET_VALUE16;
        end else begin
            timer_count_value_ff <= nxt_count;
        end
    end

    // Compare registers; A always goes through a buffer, held back when it defines top
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            compare_a_buf_ff <= RESET_VALUE16;
            compare_b_ff     <= RESET_VALUE16;
            compare_c_ff     <= RESET_VALUE16;
        end else if (wr_lo) begin
            if (addr == LOC_CMPA_LO) begin
                compare_a_buf_ff <= {holding_ff, cpu_req_in.wdata};
            end else if (addr == LOC_CMPB_LO) begin
                compare_b_ff <= {holding_ff, cpu_req_in.wdata};
            end else if (addr == LOC_CMPC_LO) begin
                compare_c_ff <= {holding_ff, cpu_req_in.wdata};
            end
        end
    end

    // Active A value follows the buffer one clock later, except when it is top:
    // then it is taken only at the top so a period never truncates
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            compare_value_a_ff <= RESET_VALUE16;
        end else if (!cmpa_defines_top) begin
            compare_value_a_ff <= compare_a_buf_ff;
        end else if (count_tick_in && at_top) begin
            compare_value_a_ff <= compare_a_buf_ff;
        end
    end

    assign pwm_a_allowed_out = !(pwm_mode_in && cmpa_defines_top);

    // Compare match flags; a new match wins over a clear
    assign match[0] = (timer_count_value_ff == compare_value_a_ff);
    assign match[1] = (timer_count_value_ff == compare_b_ff);
    assign match[2] = (timer_count_value_ff == compare_c_ff);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            compare_match_flags_ff <= 3'h0;
        end else begin
            compare_match_flags_ff <= (compare_match_flags_ff & ~flag_clear_in)
                                      | (match & {3{count_tick_in}});
        end
    end

    // Capture input: sync, filter, edge detect
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_sync_ff <= 2'h0;
            cmp_sync_ff <= 2'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[0], capture_pin_in};
            cmp_sync_ff <= {cmp_sync_ff[0], comparator_in};
        end
    end

    assign trig_src = use_comparator_in ? cmp_sync_ff[1] : pin_sync_ff[1];

    capture_filter #(
        .SAMPLES (FILTER_SAMPLES)
    ) u_filter (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .enable_in (filter_enable_in),
        .sample_in (trig_src),
        .level_out (filtered)
    );

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            edge_prev_ff <= 1'b0;
        end else begin
            edge_prev_ff <= filtered;
        end
    end

    // Capture is off while the capture register defines top
    assign capture_event = !cap_defines_top && (filtered != edge_prev_ff)
                           && (filtered == capture_rising_in);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            capture_value_ff <= RESET_VALUE16;
        end else if (capture_event) begin
            capture_value_ff <= timer_count_value_ff;
        end else if (wr_lo && (addr == LOC_CAP_LO) && cap_defines_top) begin
            capture_value_ff <= {holding_ff, cpu_req_in.wdata};
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            capture_flag_ff <= 1'b0;
        end else if (capture_event) begin
            capture_flag_ff <= 1'b1;
        end else if (capture_flag_clear_in) begin
            capture_flag_ff <= 1'b0;
        end
    end

    // Read data; compare high bytes come straight from the register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_ff <= RESET_VALUE8;
        end else if (cpu_req_in.rd) begin
            if (addr == LOC_CNT_LO) begin
                rdata_ff <= timer_count_value_ff[7:0];
            end else if (addr == LOC_CMPA_LO) begin
                rdata_ff <= compare_a_buf_ff[7:0];
            end else if (addr == LOC_CMPA_HI) begin
                rdata_ff <= compare_a_buf_ff[15:8];
            end else if (addr == LOC_CMPB_LO) begin
                rdata_ff <= compare_b_ff[7:0];
            end else if (addr == LOC_CMPB_HI) begin
                rdata_ff <= compare_b_ff[15:8];
            end else if (addr == LOC_CMPC_LO) begin
                rdata_ff <= compare_c_ff[7:0];
            end else if (addr == LOC_CMPC_HI) begin
                rdata_ff <= compare_c_ff[15:8];
            end else if (addr == LOC_CAP_LO) begin
                rdata_ff <= capture_value_ff[7:0];
            end else if (addr == LOC_CNT_HI || addr == LOC_CAP_HI) begin
                rdata_ff <= holding_ff;
            end else begin
                rdata_ff <= RESET_VALUE8;
            end
        end
    end

    assign cpu_rdata_out           = rdata_ff;
    assign compare_match_flags_out = compare_match_flags_ff;
    assign capture_flag_out        = capture_flag_ff;
    assign timer_count_value_out   = timer_count_value_ff;
    assign top_value_out           = top_value;
    assign boundary_out.bottom     = (timer_count_value_ff == BOTTOM_VALUE);
    assign boundary_out.max        = (timer_count_value_ff == MAX_VALUE);
    assign boundary_out.top        = at_top;

    // Checks
    a_low_write_load: assert property (@(posedge clock_in) disable iff (rst_in)
        cpu_wr_cnt |=> timer_count_value_ff == {$past(holding_ff), $past(cpu_req_in.wdata)})
        else $error("counter not loaded by low write");
    a_low_read_latch: assert property (@(posedge clock_in) disable iff (rst_in)
        (rd_lo && addr == LOC_CNT_LO && !cpu_req_in.wr) |=> holding_ff == $past(timer_count_value_ff[15:8]))
        else $error("holding not loaded on low read");
    a_high_write_only: assert property (@(posedge clock_in) disable iff (rst_in)
        (cpu_req_in.wr && addr[0] && !count_tick_in) |=> $stable(timer_count_value_ff) && $stable(compare_b_ff))
        else $error("high write touched a 16-bit register");
    a_cnt_high_read: assert property (@(posedge clock_in) disable iff (rst_in)
        (cpu_req_in.rd && addr == LOC_CNT_HI && !cpu_req_in.wr) |=> cpu_rdata_out == $past(holding_ff))
        else $error("counter high read not from holding");
    a_cmp_bypass: assert property (@(posedge clock_in) disable iff (rst_in)
        (cpu_req_in.rd && addr == LOC_CMPB_HI) |=> cpu_rdata_out == $past(compare_b_ff[15:8]))
        else $error("compare high read used holding");
    a_cmp_no_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (rd_lo && (addr == LOC_CMPA_LO || addr == LOC_CMPB_LO || addr == LOC_CMPC_LO)) |=> $stable(holding_ff))
        else $error("compare low read changed holding");
    a_capture_copy: assert property (@(posedge clock_in) disable iff (rst_in)
        capture_event |=> capture_value_ff == $past(timer_count_value_ff) && capture_flag_ff)
        else $error("capture did not copy counter");
    a_match_flag: assert property (@(posedge clock_in) disable iff (rst_in)
        (count_tick_in && match[1]) |=> compare_match_flags_ff[1])
        else $error("compare match flag B not set");
    a_top_buffered: assert property (@(posedge clock_in) disable iff (rst_in)
        (cmpa_defines_top && $past(cmpa_defines_top) && !$past(count_tick_in && at_top))
        |-> $stable(compare_value_a_ff))
        else $error("top changed outside top");
    a_pwm_a_block: assert property (@(posedge clock_in) disable iff (rst_in)
        (pwm_mode_in && top_sel_in == TOP_SEL_CMPA) |-> !pwm_a_allowed_out)
        else $error("pwm a allowed with A as top");
    a_fixed_top: assert property (@(posedge clock_in) disable iff (rst_in)
        top_sel_in == TOP_SEL_9BIT |-> top_value_out == 16'h01FF)
        else $error("wrong fixed top");
    a_bottom_flag: assert property (@(posedge clock_in) disable iff (rst_in)
        boundary_out.bottom == (timer_count_value_out == 16'h0000) && boundary_out.max == (&timer_count_value_out))
        else $error("boundary indication wrong");

endmodule : timer16_access

// >>> verilog/timer16_pkg.sv
package timer16_pkg;

    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // Byte locations on the 8-bit access port
    localparam logic [3:0] LOC_CNT_LO = 4'h0;
    localparam logic [3:0] LOC_CNT_HI = 4'h1;
    localparam logic [3:0] LOC_CMPA_LO = 4'h2;
    localparam logic [3:0] LOC_CMPA_HI = 4'h3;
    localparam logic [3:0] LOC_CMPB_LO = 4'h4;
    localparam logic [3:0] LOC_CMPB_HI = 4'h5;
    localparam logic [3:0] LOC_CMPC_LO = 4'h6;
    localparam logic [3:0] LOC_CMPC_HI = 4'h7;
    localparam logic [3:0] LOC_CAP_LO = 4'h8;
    localparam logic [3:0] LOC_CAP_HI = 4'h9;

    localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
    localparam logic [15:0] MAX_VALUE    = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;
    localparam logic [15:0] RESET_VALUE16 = 16'h0000;
    localparam logic [7:0]  RESET_VALUE8  = 8'h00;

    localparam int FILTER_SAMPLES = 4;

    typedef enum logic [2:0] {
        TOP_SEL_MAX,
        TOP_SEL_8BIT,
        TOP_SEL_9BIT,
        TOP_SEL_10BIT,
        TOP_SEL_CMPA,
        TOP_SEL_CAP
    } top_sel_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } cpu_req_type;

    typedef struct packed {
        logic bottom;
        logic max;
        logic top;
    } boundary_type;

endpackage : timer16_pkg

// >>> verilog/capture_filter.sv
`timescale 1ns/10ps
module capture_filter
    import timer16_pkg::*;
#(
    parameter int SAMPLES = FILTER_SAMPLES
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic enable_in,
    input  wire logic sample_in,
    output logic      level_out
);
    logic [SAMPLES-1:0] hist_ff;
    logic               level_ff;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[SAMPLES-2:0], sample_in};
        end
    end

    // Output moves only when all samples agree; bypass when disabled
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            level_ff <= 1'b0;
        end else if (!enable_in) begin
            level_ff <= sample_in;
        end else if (&hist_ff) begin
            level_ff <= 1'b1;
        end else if (~|hist_ff) begin
            level_ff <= 1'b0;
        end
    end

    assign level_out = level_ff;

endmodule : capture_filter

// >>> verif/cpu_bus_model.sv
`timescale 1ns/10ps
module cpu_bus_model
    import timer16_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    output cpu_req_type     req_out
);
    initial req_out = '0;

    // Released bus shows inverted address and data, never a stale copy
    task automatic idle();
        @(negedge clock_in);
        req_out = '{rd: 1'b0, wr: 1'b0, addr: ~req_out.addr, wdata: ~req_out.wdata};
    endtask : idle

    task automatic put(input logic rd, input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(negedge clock_in);
        req_out = '{rd: rd, wr: wr, addr: a, wdata: d};
    endtask : put

    // High byte goes first so the low byte commits the whole word
    task automatic write16(input logic [3:0] lo, input logic [15:0] v);
        put(1'b0, 1'b1, lo + 4'h1, v[15:8]);
        put(1'b0, 1'b1, lo, v[7:0]);
        idle();
    endtask : write16

    // Back to back and never split, so nothing else can touch the holding byte
    task automatic read16(input logic [3:0] lo, output logic [15:0] v);
        put(1'b1, 1'b0, lo, 8'h00);
        put(1'b1, 1'b0, lo + 4'h1, 8'h00);
        v[7:0] = rdata_in;
        idle();
        v[15:8] = rdata_in;
    endtask : read16
endmodule : cpu_bus_model

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb
    import timer16_pkg::*;
;
    logic         clk;
    logic         rst;
    logic         tick;
    logic         up;
    logic         clr;
    top_sel_type  tsel;
    logic         pwm;
    logic         pin;
    logic         cmp;
    logic         use_cmp;
    logic         filt;
    logic         rise;
    logic [2:0]   fclr;
    logic         cclr;
    cpu_req_type  req;
    logic [7:0]   rdata;
    logic [2:0]   flags;
    logic         cflag;
    logic         pwm_ok;
    boundary_type bnd;
    logic [15:0]  cnt;
    logic [15:0]  top;
    logic [15:0]  rv;
    int           err_count;
    int           cmp_count;

    timer16_access u_timer16_access (
        .clock_in(clk), .rst_in(rst), .cpu_req_in(req), .cpu_rdata_out(rdata),
        .count_tick_in(tick), .count_up_in(up), .count_clear_in(clr),
        .top_sel_in(tsel), .pwm_mode_in(pwm), .capture_pin_in(pin),
        .comparator_in(cmp), .use_comparator_in(use_cmp), .filter_enable_in(filt),
        .capture_rising_in(rise), .flag_clear_in(fclr), .capture_flag_clear_in(cclr),
        .compare_match_flags_out(flags), .capture_flag_out(cflag),
        .pwm_a_allowed_out(pwm_ok), .boundary_out(bnd),
        .timer_count_value_out(cnt), .top_value_out(top)
    );

    cpu_bus_model u_cpu_bus_model (.clock_in(clk), .rdata_in(rdata), .req_out(req));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // Ticks stay high across n edges so the strobe is never set twice in one step
    task automatic ticks(input int n);
        @(negedge clk);
        tick = 1'b1;
        repeat (n) @(negedge clk);
        tick = 1'b0;
    endtask : ticks

    task automatic t_reset();
        check(16'(rdata), 16'h0000, "rdata at reset");
        check(cnt, 16'h0000, "count at reset");
        check(16'(flags), 16'h0000, "flags at reset");
        check(16'(bnd.bottom), 16'h0001, "bottom at reset");
        check(16'(bnd.max), 16'h0000, "max at reset");
    endtask : t_reset

    task automatic t_counter();
        u_cpu_bus_model.write16(LOC_CNT_LO, 16'h01FF);
        check(cnt, 16'h01FF, "count after word write");
        u_cpu_bus_model.put(1'b0, 1'b1, LOC_CNT_HI, 8'hA5);
        u_cpu_bus_model.idle();
        check(cnt, 16'h01FF, "high write alone");
        u_cpu_bus_model.read16(LOC_CNT_LO, rv);
        check(rv, 16'h01FF, "count read back");
        u_cpu_bus_model.put(1'b0, 1'b1, LOC_CNT_LO, 8'h34);
        u_cpu_bus_model.idle();
        check(cnt, 16'h0134, "low write uses byte from low read");
    endtask : t_counter

    task automatic t_shared();
        u_cpu_bus_model.put(1'b0, 1'b1, LOC_CMPB_HI, 8'h12);
        u_cpu_bus_model.put(1'b0, 1'b1, LOC_CMPB_LO, 8'h34);
        u_cpu_bus_model.put(1'b0, 1'b1, LOC_CMPC_LO, 8'h56);
        u_cpu_bus_model.read16(LOC_CNT_LO, rv);
        u_cpu_bus_model.put(1'b1, 1'b0, LOC_CMPB_HI, 8'h00);
        u_cpu_bus_model.idle();
        check(16'(rdata), 16'h0012, "compare high read direct");
        u_cpu_bus_model.read16(LOC_CMPC_LO, rv);
        check(rv, 16'h1256, "shared high byte reused");
        u_cpu_bus_model.put(1'b0, 1'b1, LOC_CNT_LO, 8'h78);
        u_cpu_bus_model.idle();
        check(cnt, 16'h0178, "compare reads left holding alone");
    endtask : t_shared

    task automatic t_tops();
        top_sel_type sels[4] = '{TOP_SEL_8BIT, TOP_SEL_9BIT, TOP_SEL_10BIT, TOP_SEL_MAX};
        logic [15:0] vals[4] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'hFFFF};
        foreach (sels[i]) begin
            @(negedge clk);
            tsel = sels[i];
            @(negedge clk);
            check(top, vals[i], "fixed top");
        end
        u_cpu_bus_model.write16(LOC_CNT_LO, 16'hFFFF);
        check(16'(bnd.max), 16'h0001, "max at all ones");
        check(16'(bnd.bottom), 16'h0000, "no bottom at all ones");
        u_cpu_bus_model.write16(LOC_CMPA_LO, 16'h0300);
        tsel = TOP_SEL_CAP;
        pwm = 1'b1;
        u_cpu_bus_model.write16(LOC_CAP_LO, 16'h0777);
        check(top, 16'h0777, "capture as top");
        check(16'(pwm_ok), 16'h0001, "pwm A free with capture top");
        @(negedge clk);
        tsel = TOP_SEL_CMPA;
        @(negedge clk);
        check(top, 16'h0300, "compare A as top");
        check(16'(pwm_ok), 16'h0000, "pwm A blocked with A top");
    endtask : t_tops

    task automatic t_dbuf();
        u_cpu_bus_model.write16(LOC_CNT_LO, 16'h0010);
        u_cpu_bus_model.write16(LOC_CMPA_LO, 16'h0050);
        ticks(2);
        check(top, 16'h0300, "top held mid count");
        u_cpu_bus_model.write16(LOC_CNT_LO, 16'h0300);
        check(16'(bnd.top), 16'h0001, "top reached");
        ticks(1);
        @(negedge clk);
        check(top, 16'h0050, "top loaded at top");
        check(16'(bnd.bottom), 16'h0001, "wrapped to bottom at top");
        pwm = 1'b0;
    endtask : t_dbuf

    // Down count through zero, then a clear on tick
    task automatic t_dir();
        u_cpu_bus_model.write16(LOC_CNT_LO, 16'h0001);
        up = 1'b0;
        ticks(2);
        check(cnt, 16'hFFFF, "down count wraps");
        check(16'(bnd.max), 16'h0001, "max after down wrap");
        clr = 1'b1;
        ticks(1);
        check(cnt, 16'h0000, "clear on tick");
        check(16'(bnd.bottom), 16'h0001, "bottom after clear");
        up = 1'b1;
        clr = 1'b0;
    endtask : t_dir

    task automatic t_match();
        logic [15:0] cv[3] = '{16'h0040, 16'h0080, 16'h00C0};
        @(negedge clk);
        tsel = TOP_SEL_MAX;
        u_cpu_bus_model.write16(LOC_CMPA_LO, cv[0]);
        u_cpu_bus_model.write16(LOC_CMPB_LO, cv[1]);
        u_cpu_bus_model.write16(LOC_CMPC_LO, cv[2]);
        foreach (cv[i]) begin
            u_cpu_bus_model.write16(LOC_CNT_LO, cv[i] - 16'h0001);
            fclr = 3'h7;
            @(negedge clk);
            fclr = 3'h0;
            ticks(3);
            @(negedge clk);
            check(16'(flags), 16'(3'h1 << i), "compare match flag");
        end
    endtask : t_match

    // One capture on the chosen source; with the filter on a short spike comes first
    task automatic t_cap(input logic src, input logic r, input logic f, input logic [15:0] v);
        @(negedge clk);
        use_cmp = src;
        rise = r;
        filt = f;
        pin = ~r;
        cmp = ~r;
        repeat (12) @(negedge clk);
        u_cpu_bus_model.write16(LOC_CNT_LO, v);
        cclr = 1'b1;
        @(negedge clk);
        cclr = 1'b0;
        if (f) begin
            if (src) cmp = r; else pin = r;
            repeat (2) @(negedge clk);
            if (src) cmp = ~r; else pin = ~r;
            repeat (12) @(negedge clk);
            check(16'(cflag), 16'h0000, "spike rejected");
        end
        if (src) cmp = r; else pin = r;
        for (int i = 0; i < 20 && cflag !== 1'b1; i++) @(negedge clk);
        check(16'(cflag), 16'h0001, "capture flag");
        u_cpu_bus_model.read16(LOC_CAP_LO, rv);
        check(rv, v, "captured count");
    endtask : t_cap

    initial begin
        #(25 * 6000);
        err_count++;
        close_out();
    end

    initial begin
        err_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        {tick, pwm, pin, cmp, use_cmp, filt, rise, cclr, clr} = '0;
        up = 1'b1;
        tsel = TOP_SEL_MAX;
        fclr = 3'h0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_counter();
        t_shared();
        t_tops();
        t_dbuf();
        t_match();
        t_dir();
        t_cap(1'b0, 1'b1, 1'b0, 16'h1234);
        t_cap(1'b1, 1'b0, 1'b0, 16'h2345);
        t_cap(1'b0, 1'b1, 1'b1, 16'h3456);
        close_out();
    end
endmodule : tb
